// ### common/power_seq_pkg.sv
// constants shared by the reader power-mode sequencer
package power_seq_pkg;

  // ---------------------------------------------------------------
  // clock
  // ---------------------------------------------------------------
  localparam int CLK_HZ        = 100_000_000;
  localparam int CLK_PERIOD_NS = 10;

  // ---------------------------------------------------------------
  // register map
  // ---------------------------------------------------------------
  localparam logic [5:0] CHIP_STATE_CONTROL_OFS       = 6'h00;
  localparam logic [5:0] SUPPLY_REGULATOR_CONTROL_OFS = 6'h0b;
  localparam logic [7:0] CHIP_STATE_CONTROL_RST       = 8'h00;
  localparam logic [7:0] SUPPLY_REGULATOR_CONTROL_RST = 8'h80;

  // chip_state_control fields
  localparam int CSC_RANGE_5V_BIT = 0;
  localparam int CSC_RX_ON_BIT    = 1;
  localparam int CSC_TX_LEVEL_BIT = 4;
  localparam int CSC_RF_ON_BIT    = 5;
  localparam int CSC_STANDBY_BIT  = 7;

  // supply_regulator_control fields
  localparam int SRC_AUTO_BIT  = 7;
  localparam int SRC_CODE_MSB  = 2;
  localparam int SRC_HEAD_MSB  = 1;
  localparam logic [1:0] HEADROOM_400MV = 2'h0;
  localparam logic [1:0] HEADROOM_RSVD  = 2'h1;

  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int AUX_CLK_HZ          = 60_000;
  localparam int AUX_HALF_CYCLES     = CLK_HZ / (2 * AUX_CLK_HZ);
  localparam int XTAL_HALF_CYCLES    = 1;
  localparam int WAKE_TIMEOUT_NS     = 100_000;
  localparam int WAKE_TIMEOUT_CYCLES = WAKE_TIMEOUT_NS / CLK_PERIOD_NS;
  localparam int STBY_RECOVER_NS     = 100_000;
  localparam int STBY_RECOVER_CYCLES =
    (STBY_RECOVER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RFOFF_RECOVER_NS     = 25_000;
  localparam int RFOFF_RECOVER_CYCLES =
    (RFOFF_RECOVER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TIMER_W = 16;

  typedef enum logic [2:0] {
    ST_OFF,
    ST_PARTIAL,
    ST_START,
    ST_WAKE_HOLD,
    ST_RUN
  } pwr_state_type;

endpackage

// ### rtl/reader_power_mode_sequencer.sv
// power-state, host-clock and regulator-setting control of the reader front end
// What this block does
// R01: control bit 0 selects 5-V or 3-V range
// R02: manual mode: bits 2:0 pick 2.7..3.4 V
// R03: auto mode: bits 1:0 pick headroom, bit2 ignored
// R04: auto headroom code 01 treated as 00
// R05: auto reconfigure on enable rise, auto-bit rise
// R06: seven power states from pins and bits
// R07: main enable high turns on rails, oscillator, clock
// R08: aux pin alone keeps I/O rail, 60 kHz
// R09: both pins low: complete power down, no clock
// R10: aux rising edge starts supplies like main enable
// R11: after wake, main enable within 100 us else off
// R12: crystal clock only after settled and stable
// R13: host picks modes after enable and ready
// R14: standby bit: low-power rails, RF ignored, 100 us
// R15: RF and receiver off: active, 25 us recovery
// R16: receiver-only mode when only bit 1 set
// R17: RF on: tx and rx, bit 4 half power
`timescale 1ns/10ps
module reader_power_mode_sequencer
  import power_seq_pkg::*;
#(
  parameter int WAKE_CYCLES  = WAKE_TIMEOUT_CYCLES,
  parameter int STBY_CYCLES  = STBY_RECOVER_CYCLES
)
(
  input  wire logic       core_clk,
  input  wire logic       rst_n,
  input  wire logic       main_enable,
  input  wire logic       aux_wake_input,
  input  wire logic       supply_settled,
  input  wire logic       osc_stable,
  input  wire logic       reg_wr_en,
  input  wire logic       reg_rd_en,
  input  wire logic [5:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  output logic      [7:0] reg_rdata,
  output logic            regulators_on,
  output logic            regulators_low_power,
  output logic            io_rail_on,
  output logic            osc_enable,
  output logic            host_clock_output,
  output logic            host_clock_crystal,
  output logic            device_ready,
  output logic            rf_ready,
  output logic            rx_enable,
  output logic            tx_enable,
  output logic            tx_stage_rail,
  output logic            tx_output_level_select,
  output logic            supply_range_5v,
  output logic            regulator_auto,
  output logic      [2:0] regulator_code,
  output logic      [1:0] regulator_headroom,
  output logic            regulator_reconfig
);
  // -------------------------------------------------------------------
  // pin synchronisers
  // -------------------------------------------------------------------
  logic [3:0] sync1_q;
  logic [3:0] sync2_q;
  logic [3:0] prev_q;
  logic       en_s;
  logic       aux_s;
  logic       settled_s;
  logic       stable_s;
  logic       en_rise;
  logic       aux_rise;
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sync1_q <= 4'h0;
      sync2_q <= 4'h0;
      prev_q  <= 4'h0;
    end
    else
    begin
      sync1_q <= {osc_stable, supply_settled, aux_wake_input, main_enable};
      sync2_q <= sync1_q;
      prev_q  <= sync2_q;
    end
  end
  assign en_s      = sync2_q[0];
  assign aux_s     = sync2_q[1];
  assign settled_s = sync2_q[2];
  assign stable_s  = sync2_q[3];
  assign en_rise   = sync2_q[0] & ~prev_q[0];
  assign aux_rise  = sync2_q[1] & ~prev_q[1];
  // -------------------------------------------------------------------
  // registers
  // -------------------------------------------------------------------
  logic [7:0] csc_q;
  logic [7:0] csc_d;
  logic [7:0] src_q;
  logic [7:0] src_d;
  logic [7:0] rdata_d;
  logic [1:0] head_d;
  logic [1:0] head_q;
  logic       reconf_d;
  logic       reconf_q;
  logic       auto_rise;
  always_comb
  begin
    csc_d   = csc_q;
    src_d   = src_q;
    rdata_d = reg_rdata;
    if (reg_wr_en && reg_addr == CHIP_STATE_CONTROL_OFS)
      csc_d = reg_wdata;
    if (reg_wr_en && reg_addr == SUPPLY_REGULATOR_CONTROL_OFS)
      src_d = reg_wdata;
    if (reg_rd_en)
    begin
      case (reg_addr)
        CHIP_STATE_CONTROL_OFS:       rdata_d = csc_q;
        SUPPLY_REGULATOR_CONTROL_OFS: rdata_d = src_q;
        default:                      rdata_d = 8'h00;
      endcase
    end
  end
  // a fresh auto setting is taken on enable rise or on a 0-to-1 auto bit
  assign auto_rise = src_d[SRC_AUTO_BIT] & ~src_q[SRC_AUTO_BIT]; // R05
  always_comb
  begin
    head_d   = head_q;
    reconf_d = 1'b0;
    if (src_d[SRC_AUTO_BIT] && (auto_rise || en_rise)) // R05
    begin
      reconf_d = 1'b1;
      head_d   = src_d[SRC_HEAD_MSB:0]; // R03
      if (src_d[SRC_HEAD_MSB:0] == HEADROOM_RSVD)
        head_d = HEADROOM_400MV; // R04
    end
  end
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      csc_q     <= CHIP_STATE_CONTROL_RST;
      src_q     <= SUPPLY_REGULATOR_CONTROL_RST;
      reg_rdata <= 8'h00;
      head_q    <= HEADROOM_400MV;
      reconf_q  <= 1'b0;
    end
    else
    begin
      csc_q     <= csc_d;
      src_q     <= src_d;
      reg_rdata <= rdata_d;
      head_q    <= head_d;
      reconf_q  <= reconf_d;
    end
  end
  assign supply_range_5v    = csc_q[CSC_RANGE_5V_BIT]; // R01
  assign regulator_auto     = src_q[SRC_AUTO_BIT];
  assign regulator_code     = src_q[SRC_CODE_MSB:0]; // R02
  assign regulator_headroom = head_q;
  assign regulator_reconfig = reconf_q;
  // -------------------------------------------------------------------
  // power state machine
  // -------------------------------------------------------------------
  pwr_state_type         state_q;
  pwr_state_type         state_d;
  logic                  woke_q;
  logic                  woke_d;
  logic [TIMER_W-1:0]    timer_q;
  logic [TIMER_W-1:0]    timer_d;
  logic                  stby_prev_q;
  logic                  idle_prev_q;
  logic                  rf_idle;
  assign rf_idle = ~csc_q[CSC_RF_ON_BIT] & ~csc_q[CSC_RX_ON_BIT];
  always_comb
  begin
    state_d = state_q;
    woke_d  = woke_q;
    timer_d = (timer_q != '0) ? timer_q - 1'b1 : timer_q;
    case (state_q)
      ST_OFF, ST_PARTIAL:
      begin
        woke_d  = 1'b0;
        state_d = aux_s ? ST_PARTIAL : ST_OFF; // R08 R09
        if (en_s)
          state_d = ST_START; // R07
        else if (aux_rise)
        begin
          state_d = ST_START; // R10
          woke_d  = 1'b1;
        end
      end
      ST_START:
      begin
        if (!en_s && !woke_q)
          state_d = ST_OFF;
        else if (settled_s && stable_s) // R12
        begin
          if (en_s)
            state_d = ST_RUN;
          else
          begin
            state_d = ST_WAKE_HOLD;
            timer_d = TIMER_W'(WAKE_CYCLES); // R11
          end
        end
      end
      ST_WAKE_HOLD:
      begin
        if (en_s)
          state_d = ST_RUN; // R11
        else if (timer_q == '0)
          state_d = ST_OFF; // R11
      end
      ST_RUN:
      begin
        woke_d = 1'b0;
        if (!en_s)
          state_d = ST_OFF;
        else if (stby_prev_q && !csc_q[CSC_STANDBY_BIT])
          timer_d = TIMER_W'(STBY_CYCLES); // R14
        else if (idle_prev_q && !rf_idle && !csc_q[CSC_STANDBY_BIT])
          timer_d = TIMER_W'(RFOFF_RECOVER_CYCLES); // R15
      end
      default:
        state_d = ST_OFF;
    endcase
  end
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_q     <= ST_OFF;
      woke_q      <= 1'b0;
      timer_q     <= '0;
      stby_prev_q <= 1'b0;
      idle_prev_q <= 1'b0;
    end
    else
    begin
      state_q     <= state_d;
      woke_q      <= woke_d;
      timer_q     <= timer_d;
      stby_prev_q <= csc_q[CSC_STANDBY_BIT];
      idle_prev_q <= rf_idle;
    end
  end
  // -------------------------------------------------------------------
  // mode outputs
  // -------------------------------------------------------------------
  logic running;
  logic stby;
  assign running = (state_q == ST_RUN);
  assign stby    = csc_q[CSC_STANDBY_BIT];
  assign device_ready = running | (state_q == ST_WAKE_HOLD);
  assign host_clock_crystal = device_ready; // R12
  assign regulators_on = (state_q == ST_START) | device_ready; // R07 R10
  assign osc_enable    = regulators_on;
  assign io_rail_on    = regulators_on | (state_q == ST_PARTIAL); // R08
  assign regulators_low_power = running & stby; // R14
  // RF bits act only out of standby, as the mode decode of the register
  assign tx_enable     = running & ~stby & csc_q[CSC_RF_ON_BIT]; // R06 R17
  assign rx_enable     = running & ~stby & (csc_q[CSC_RF_ON_BIT] | csc_q[CSC_RX_ON_BIT]); // R16
  assign tx_stage_rail = tx_enable;
  assign tx_output_level_select = tx_enable & csc_q[CSC_TX_LEVEL_BIT]; // R17
  assign rf_ready      = running & ~stby & ~stby_prev_q & ~(idle_prev_q & ~rf_idle)
                         & (timer_q == '0); // R14 R15
  // -------------------------------------------------------------------
  // host clock: 60 kHz aux or crystal-derived, none when fully off
  // -------------------------------------------------------------------
  logic [9:0] div_q;
  logic [9:0] div_d;
  logic       hclk_d;
  logic [9:0] half_lim;
  assign half_lim = host_clock_crystal ? 10'(XTAL_HALF_CYCLES - 1)
                                       : 10'(AUX_HALF_CYCLES - 1);
  always_comb
  begin
    div_d  = div_q + 10'h001;
    hclk_d = host_clock_output;
    if (state_q == ST_OFF)
    begin
      div_d  = 10'h000; // R09
      hclk_d = 1'b0;
    end
    else if (div_q >= half_lim)
    begin
      div_d  = 10'h000; // R08
      hclk_d = ~host_clock_output;
    end
  end
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      div_q             <= 10'h000;
      host_clock_output <= 1'b0;
    end
    else
    begin
      div_q             <= div_d;
      host_clock_output <= hclk_d;
    end
  end
  // -------------------------------------------------------------------
  // checks
  // -------------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  AST_RANGE: assert property (reg_wr_en && reg_addr == CHIP_STATE_CONTROL_OFS // R01
      |=> supply_range_5v == $past(reg_wdata[CSC_RANGE_5V_BIT]))
    else $error("range bit not reflected");
  AST_MANUAL_CODE: assert property (reg_wr_en && reg_addr == SUPPLY_REGULATOR_CONTROL_OFS // R02
      |=> regulator_code == $past(reg_wdata[2:0]))
    else $error("manual code not taken");
  AST_HEAD_RSVD: assert property (regulator_headroom != HEADROOM_RSVD) // R04
    else $error("reserved headroom code used");
  AST_RECONF: assert property (en_rise && src_q[7] |=> regulator_reconfig) // R05
    else $error("no reconfigure on enable rise");
  AST_HEAD_TAKE: assert property (reconf_d |=> regulator_headroom // R03
      == ($past(src_d[1:0]) == 2'h1 ? 2'h0 : $past(src_d[1:0])))
    else $error("headroom not captured");
  AST_OFF_QUIET: assert property (state_q == ST_OFF |=> !host_clock_output) // R09
    else $error("clock runs in power down");
  AST_CRYSTAL: assert property ($rose(host_clock_crystal) |-> $past(settled_s && stable_s)) // R12
    else $error("crystal clock before stable");
  AST_TIMEOUT: assert property (state_q == ST_WAKE_HOLD && timer_q == '0 && !en_s // R11
      |=> state_q == ST_OFF)
    else $error("wake hold did not time out");
  AST_WAKE: assert property (state_q == ST_OFF && !en_s && aux_rise |=> regulators_on) // R10
    else $error("aux edge did not start supplies");
  AST_STBY: assert property (regulators_low_power |-> !tx_enable && !rx_enable) // R14
    else $error("RF active in standby");
  AST_TX: assert property (tx_enable |-> rx_enable) // R17
    else $error("tx without rx");
  AST_RECOVER: assert property ($fell(stby) || $fell(rf_idle) |-> !rf_ready) // R14 R15
    else $error("rf ready while recovery starts");
  COV_WAKE_TIMEOUT: cover property (state_q == ST_WAKE_HOLD ##1 state_q == ST_OFF);
  COV_WAKE_RUN: cover property (state_q == ST_WAKE_HOLD ##1 state_q == ST_RUN);
  COV_HALF_TX: cover property (tx_output_level_select);
  COV_PARTIAL: cover property (state_q == ST_PARTIAL && host_clock_output);
endmodule

// ### dv/host_model.sv
// host controller model: drives the enable pins and the register strobes
`timescale 1ns/10ps
module host_model
(
  input  wire logic       core_clk,
  input  wire logic [7:0] reg_rdata,
  output logic            main_enable,
  output logic            aux_wake_input,
  output logic            reg_wr_en,
  output logic            reg_rd_en,
  output logic      [5:0] reg_addr,
  output logic      [7:0] reg_wdata
);
  initial
  begin
    main_enable    = 1'b0;
    aux_wake_input = 1'b0;
    reg_wr_en      = 1'b0;
    reg_rd_en      = 1'b0;
    reg_addr       = 6'h2a;
    reg_wdata      = 8'h5a;
  end

  // -------------------------------------------------------------
  // bus cycles
  // -------------------------------------------------------------
  // mode bytes are only sent once the device reports ready
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    @(posedge core_clk);
    #1;
    reg_addr  = a;
    reg_wdata = d;
    reg_wr_en = 1'b1;
    @(posedge core_clk);
    #1;
    reg_wr_en = 1'b0;
    // released lines show the inverse so stale values never look valid
    reg_addr  = ~a;
    reg_wdata = ~d;
  endtask

  task automatic rd(input logic [5:0] a, output logic [7:0] d);
    @(posedge core_clk);
    #1;
    reg_addr  = a;
    reg_rd_en = 1'b1;
    @(posedge core_clk);
    #1;
    reg_rd_en = 1'b0;
    reg_addr  = ~a;
    d         = reg_rdata;
  endtask

  // sets both enable pins together; only the confirmed-wake test follows an aux wake with main enable
  task automatic pins(input logic en, input logic aux);
    @(posedge core_clk);
    #1;
    main_enable    = en;
    aux_wake_input = aux;
  endtask
endmodule

// ### dv/reader_power_mode_sequencer_tb.sv
// self-checking bench of the reader power-mode sequencer
`timescale 1ns/10ps
module reader_power_mode_sequencer_tb;
  import power_seq_pkg::*;
  localparam int WAKE_N = 20;
  logic        core_clk = 1'b0;
  logic        rst_n    = 1'b0;
  logic        supply_settled = 1'b1;
  logic        osc_stable     = 1'b1;
  logic        main_enable, aux_wake_input, reg_wr_en, reg_rd_en;
  logic [5:0]  reg_addr;
  logic [7:0]  reg_wdata, reg_rdata, rb;
  logic        regulators_on, regulators_low_power, io_rail_on, osc_enable;
  logic        host_clock_output, host_clock_crystal, device_ready, rf_ready;
  logic        rx_enable, tx_enable, tx_stage_rail, tx_output_level_select;
  logic        supply_range_5v, regulator_auto, regulator_reconfig;
  logic [2:0]  regulator_code;
  logic [1:0]  regulator_headroom;
  int          err_count = 0;
  int          check_count = 0;
  int          half_n;
  // rows: csc byte, src byte, {lp,rx,tx,half,5v,reconfig,auto,code,headroom}
  logic [7:0]  row_csc [8] = '{8'h00, 8'h02, 8'h20, 8'h30, 8'h22, 8'h80, 8'ha2, 8'h01};
  logic [7:0]  row_src [8] = '{8'h07, 8'h83, 8'h00, 8'h86, 8'h02, 8'h81, 8'h05, 8'h87};
  logic [11:0] row_exp [8] = '{12'h01c, 12'h46f, 12'h603, 12'h77a,
                               12'h60a, 12'h864, 12'h814, 12'h0ff};

  always #(CLK_PERIOD_NS / 2) core_clk = ~core_clk;

  host_model host_model_inst (.core_clk(core_clk), .reg_rdata(reg_rdata),
    .main_enable(main_enable), .aux_wake_input(aux_wake_input), .reg_wr_en(reg_wr_en),
    .reg_rd_en(reg_rd_en), .reg_addr(reg_addr), .reg_wdata(reg_wdata));

  reader_power_mode_sequencer #(.WAKE_CYCLES(WAKE_N), .STBY_CYCLES(20))
    reader_power_mode_sequencer_inst (.core_clk(core_clk), .rst_n(rst_n),
    .main_enable(main_enable), .aux_wake_input(aux_wake_input),
    .supply_settled(supply_settled), .osc_stable(osc_stable), .reg_wr_en(reg_wr_en),
    .reg_rd_en(reg_rd_en), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .regulators_on(regulators_on),
    .regulators_low_power(regulators_low_power), .io_rail_on(io_rail_on),
    .osc_enable(osc_enable), .host_clock_output(host_clock_output),
    .host_clock_crystal(host_clock_crystal), .device_ready(device_ready),
    .rf_ready(rf_ready), .rx_enable(rx_enable), .tx_enable(tx_enable),
    .tx_stage_rail(tx_stage_rail), .tx_output_level_select(tx_output_level_select),
    .supply_range_5v(supply_range_5v), .regulator_auto(regulator_auto),
    .regulator_code(regulator_code), .regulator_headroom(regulator_headroom),
    .regulator_reconfig(regulator_reconfig));

  // -------------------------------------------------------------
  // checking helpers
  // -------------------------------------------------------------
  task automatic results();
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task automatic chk_bit(input logic got, input logic exp, input string what);
    check_count++;
    if (got !== exp)
    begin
      err_count++;
      $display("wrong value at %0t: %s got %b", $time, what, got);
    end
  endtask

  task automatic chk_vec(input logic [11:0] got, input logic [11:0] exp, input string what);
    check_count++;
    if (got !== exp)
    begin
      err_count++;
      $display("wrong value at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask

  function automatic logic pick(input int sel);
    case (sel)
      0: pick = device_ready;
      1: pick = rf_ready;
      2: pick = host_clock_output;
      default: pick = regulators_on;
    endcase
  endfunction

  // bounded wait; a wait that runs out ends the run as a failure
  task automatic wait_for(input int sel, input logic v, input int bound);
    int i;
    for (i = 0; i < bound && pick(sel) !== v; i++)
    begin
      @(posedge core_clk);
      #1;
    end
    check_count++;
    if (pick(sel) !== v)
    begin
      err_count++;
      $display("wrong value at %0t: wait %0d timed out", $time, sel);
      results();
    end
  endtask

  // -------------------------------------------------------------
  // main sequence
  // -------------------------------------------------------------
  initial
  begin
    repeat (10) @(posedge core_clk);
    #1;
    rst_n = 1'b1;
    chk_bit(regulators_on | host_clock_output | io_rail_on, 1'b0, "off outputs");
    chk_bit(regulator_auto, 1'b1, "auto default");
    host_model_inst.rd(CHIP_STATE_CONTROL_OFS, rb);
    chk_vec({4'h0, rb}, {4'h0, CHIP_STATE_CONTROL_RST}, "csc reset");
    host_model_inst.rd(SUPPLY_REGULATOR_CONTROL_OFS, rb);
    chk_vec({4'h0, rb}, {4'h0, SUPPLY_REGULATOR_CONTROL_RST}, "src reset");
    host_model_inst.rd(6'h3f, rb);
    chk_vec({4'h0, rb}, 12'h000, "unmapped read");
    $display("test reset done");
    host_model_inst.pins(1'b1, 1'b0);
    wait_for(0, 1'b1, 40);
    chk_vec({9'h0, regulators_on, osc_enable, host_clock_crystal}, 12'h007, "run");
    rb[0] = host_clock_output;
    @(posedge core_clk);
    #1;
    chk_bit(host_clock_output, ~rb[0], "crystal host clock");
    $display("test enable done");
    for (int r = 0; r < 8; r++)
    begin
      host_model_inst.wr(CHIP_STATE_CONTROL_OFS, row_csc[r]);
      host_model_inst.wr(SUPPLY_REGULATOR_CONTROL_OFS, row_src[r]);
      chk_vec({regulators_low_power, rx_enable, tx_enable, tx_output_level_select,
               supply_range_5v, regulator_reconfig, regulator_auto, regulator_code,
               regulator_headroom}, row_exp[r], "mode row");
      chk_bit(tx_stage_rail, row_exp[r][9], "tx rail");
    end
    $display("test mode table done");
    chk_bit(rf_ready, 1'b0, "standby recovery");
    wait_for(1, 1'b1, 40);
    host_model_inst.wr(CHIP_STATE_CONTROL_OFS, 8'h20);
    chk_bit(rf_ready, 1'b0, "rf idle recovery start");
    @(posedge core_clk);
    #1;
    chk_bit(rf_ready, 1'b0, "rf idle recovery");
    wait_for(1, 1'b1, 2600);
    $display("test recovery done");
    host_model_inst.wr(SUPPLY_REGULATOR_CONTROL_OFS, 8'h82);
    chk_vec({9'h0, regulator_reconfig, regulator_headroom}, 12'h003, "no auto rise");
    host_model_inst.pins(1'b0, 1'b0);
    wait_for(0, 1'b0, 10);
    @(posedge core_clk);
    #1;
    chk_bit(regulators_on | host_clock_output | io_rail_on, 1'b0, "power down");
    host_model_inst.pins(1'b1, 1'b0);
    wait_for(0, 1'b1, 40);
    chk_vec({10'h0, regulator_headroom}, 12'h002, "enable reconfig");
    $display("test enable reconfig done");
    host_model_inst.pins(1'b0, 1'b0);
    supply_settled = 1'b0;
    wait_for(0, 1'b0, 10);
    host_model_inst.pins(1'b0, 1'b1);
    wait_for(3, 1'b1, 10);
    chk_bit(host_clock_crystal, 1'b0, "aux clock during start");
    supply_settled = 1'b1;
    wait_for(0, 1'b1, 10);
    repeat (WAKE_N / 2) @(posedge core_clk);
    #1;
    chk_bit(device_ready, 1'b1, "wake hold");
    wait_for(0, 1'b0, WAKE_N + 10);
    repeat (3) @(posedge core_clk);
    #1;
    chk_vec({10'h0, io_rail_on, regulators_on}, 12'h002, "partial power down");
    wait_for(2, 1'b1, 1700);
    half_n = 0;
    while (host_clock_output === 1'b1 && half_n < 1700)
    begin
      @(posedge core_clk);
      #1;
      half_n++;
    end
    chk_vec(12'(half_n), 12'(AUX_HALF_CYCLES), "aux half period");
    wait_for(2, 1'b0, 1700);
    $display("test aux wake timeout done");
    host_model_inst.pins(1'b0, 1'b0);
    repeat (4) @(posedge core_clk);
    host_model_inst.pins(1'b0, 1'b1);
    wait_for(0, 1'b1, 20);
    host_model_inst.pins(1'b1, 1'b1);
    repeat (WAKE_N * 2) @(posedge core_clk);
    #1;
    chk_bit(device_ready, 1'b1, "confirmed wake");
    $display("test confirmed wake done");
    rst_n = 1'b0;
    repeat (2) @(posedge core_clk);
    #1;
    chk_vec({9'h0, regulators_on, device_ready, regulator_auto}, 12'h001, "mid reset");
    rst_n = 1'b1;
    host_model_inst.rd(CHIP_STATE_CONTROL_OFS, rb);
    chk_vec({4'h0, rb}, 12'h000, "csc after reset");
    $display("test mid reset done");
    results();
  end
endmodule
